// ==== hw/edc_defs.svh ====
// Purpose: Constants for the external interrupt detect block
// Assumes: Core special function register bus with byte and bit access
// Notes:   Bit addresses are the bit-addressable aliases of the control byte
`ifndef EDC_DEFS_SVH
`define EDC_DEFS_SVH

// Control register byte address
`define EDC_CTRL_ADDR     8'h88
// Bit addresses of the four low control bits
`define EDC_TRIG0_BADDR   8'h88
`define EDC_FLAG0_BADDR   8'h89
`define EDC_TRIG1_BADDR   8'h8A
`define EDC_FLAG1_BADDR   8'h8B
// Field positions inside the control byte
`define EDC_TRIG0_POS     0
`define EDC_FLAG0_POS     1
`define EDC_TRIG1_POS     2
`define EDC_FLAG1_POS     3
// Reset values
`define EDC_FLAG_RST      1'b0
`define EDC_TRIG_RST      1'b0
`define EDC_PIN_IDLE      1'b1

`endif

// ==== hw/edc_pkg.sv ====
// Purpose: Types for the external interrupt detect block
// Assumes: Nothing beyond the defs header
// Notes:   Trigger encoding matches the select bit value
package edc_pkg;

  // Trigger select: 0 low level, 1 falling edge
  typedef enum logic {
    EDC_LEVEL = 1'b0,
    EDC_EDGE  = 1'b1
  } edc_trig_t;

endpackage

// ==== hw/edc_pin_detect.sv ====
// Purpose: Synchronise one active-low pin and find its falling edge
// Assumes: Pin is asynchronous to core_clk
// Notes:   A change counts once the second and third stages agree
`timescale 1ns/1ps
`include "edc_defs.svh"

module edc_pin_detect
  import edc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic pinN,
  output logic      lowLevel,
  output logic      fallPulse
);

  logic syncA_r;
  logic syncB_r;
  logic syncC_r;
  logic level_r;
  logic fall_r;
  logic level_nxt;
  logic fall_nxt;

  // Accept a new level only when the two late stages agree
  always_comb begin
    level_nxt = level_r;
    if (syncB_r == syncC_r) begin
      level_nxt = syncC_r;
    end
    fall_nxt = level_r & ~level_nxt;
  end

  // Idle-high reset so a quiet pin never fakes an edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      syncA_r <= `EDC_PIN_IDLE;
      syncB_r <= `EDC_PIN_IDLE;
      syncC_r <= `EDC_PIN_IDLE;
      level_r <= `EDC_PIN_IDLE;
      fall_r  <= 1'b0;
    end else begin
      syncA_r <= pinN;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      level_r <= level_nxt;
      fall_r  <= fall_nxt;
    end
  end

  assign lowLevel  = ~level_r;
  assign fallPulse = fall_r;

endmodule

// ==== hw/edc_ext_irq.sv ====
// Purpose: External interrupt request flags and trigger selects
// Assumes: Core drives byte and bit accesses for one cycle each
// Notes:   Upper nibble of the control byte belongs to the timers

`timescale 1ns/1ps
`include "edc_defs.svh"

// Summary of operation
// RULE1: Interrupt-1 flag set by fall or low level
// RULE2: Interrupt-0 flag set by fall or low level
// RULE3: Edge mode flag cleared on vector entry
// RULE4: Level mode flag follows pin, no clear
// RULE5: Select 1 means edge, 0 means level
// RULE6: Flags and selects reset to zero
// RULE7: Low nibble never steers the timers
// RULE8: Bits live in control byte 0x88
// RULE9: Pins synchronised, edges from successive samples
module edc_ext_irq
  import edc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       extIrq0PinN,
  input  wire logic       ext_irq1_pinN,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic       sfrRdEn,
  input  wire logic [7:0] sfrWrData,
  output logic      [7:0] sfrRdData,
  input  wire logic [7:0] bitAddr,
  input  wire logic       bitWrEn,
  input  wire logic       bitWrVal,
  output logic            bitRdVal,
  input  wire logic [1:0] vecAck,
  output logic      [1:0] extReq
);

  logic [1:0] flag_r;
  logic [1:0] sel_r;
  logic [7:0] rdData_r;
  logic       bitRd_r;
  logic [1:0] flag_nxt;
  logic [1:0] sel_nxt;
  logic [7:0] rdData_nxt;
  logic       bitRd_nxt;
  logic [1:0] lowLevel;
  logic [1:0] fallPulse;
  logic [1:0] swWr;
  logic [1:0] swVal;
  logic [3:0] nibble;

  // One detector per pin [RULE9]
  edc_pin_detect u_det0 (
    .core_clk  (core_clk),
    .srst      (srst),
    .pinN      (extIrq0PinN),
    .lowLevel  (lowLevel[0]),
    .fallPulse (fallPulse[0])
  );

  edc_pin_detect u_det1 (
    .core_clk  (core_clk),
    .srst      (srst),
    .pinN      (ext_irq1_pinN),
    .lowLevel  (lowLevel[1]),
    .fallPulse (fallPulse[1])
  );

  assign nibble = {flag_r[1], sel_r[1], flag_r[0], sel_r[0]};

  // Software access, byte write or bit write at the control byte [RULE8]
  always_comb begin
    sel_nxt = sel_r;
    swWr    = 2'h0;
    swVal   = 2'h0;
    if (sfrWrEn && sfrAddr == `EDC_CTRL_ADDR) begin
      sel_nxt[0] = sfrWrData[`EDC_TRIG0_POS];
      sel_nxt[1] = sfrWrData[`EDC_TRIG1_POS];
      swWr       = 2'h3;
      swVal      = {sfrWrData[`EDC_FLAG1_POS], sfrWrData[`EDC_FLAG0_POS]};
    end else if (bitWrEn && bitAddr == `EDC_TRIG0_BADDR) begin
      sel_nxt[0] = bitWrVal;
    end else if (bitWrEn && bitAddr == `EDC_TRIG1_BADDR) begin
      sel_nxt[1] = bitWrVal;
    end else if (bitWrEn && bitAddr == `EDC_FLAG0_BADDR) begin
      swWr[0]  = 1'h1;
      swVal[0] = bitWrVal;
    end else if (bitWrEn && bitAddr == `EDC_FLAG1_BADDR) begin
      swWr[1]  = 1'h1;
      swVal[1] = bitWrVal;
    end
  end

  // Flag update; a detected edge beats any clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    for (int i = 0; i < 2; i++) begin
      if (edc_trig_t'(sel_r[i]) == EDC_LEVEL) begin
        flag_nxt[i] = lowLevel[i]; // [RULE4] [RULE1] [RULE2] [RULE5]
      end else if (fallPulse[i]) begin
        flag_nxt[i] = 1'h1; // [RULE1] [RULE2] [RULE5]
      end else if (swWr[i]) begin
        flag_nxt[i] = swVal[i];
      end else if (vecAck[i]) begin
        flag_nxt[i] = 1'h0; // [RULE3]
      end
    end
  end

  // Registered read data; timer bits are not ours and read zero [RULE7]
  always_comb begin
    rdData_nxt = 8'h00;
    bitRd_nxt  = 1'h0;
    if (sfrRdEn && sfrAddr == `EDC_CTRL_ADDR) begin
      rdData_nxt = {4'h0, nibble};
    end
    if (bitAddr == `EDC_TRIG0_BADDR) begin
      bitRd_nxt = sel_r[0];
    end else if (bitAddr == `EDC_FLAG0_BADDR) begin
      bitRd_nxt = flag_r[0];
    end else if (bitAddr == `EDC_TRIG1_BADDR) begin
      bitRd_nxt = sel_r[1];
    end else if (bitAddr == `EDC_FLAG1_BADDR) begin
      bitRd_nxt = flag_r[1];
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag_r   <= {2{`EDC_FLAG_RST}}; // [RULE6]
      sel_r    <= {2{`EDC_TRIG_RST}}; // [RULE6]
      rdData_r <= 8'h00;
      bitRd_r  <= 1'b0;
    end else begin
      flag_r   <= flag_nxt;
      sel_r    <= sel_nxt;
      rdData_r <= rdData_nxt;
      bitRd_r  <= bitRd_nxt;
    end
  end

  assign sfrRdData = rdData_r;
  assign bitRdVal  = bitRd_r;
  assign extReq    = flag_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence edgeMode1_s;
    sel_r[1] && fallPulse[1];
  endsequence

  sequence edgeMode0_s;
    sel_r[0] && fallPulse[0];
  endsequence

  sequence pinHeldLow0_s;
    (!sel_r[0] && !extIrq0PinN) [*6];
  endsequence

  edgeSet1_a: assert property (edgeMode1_s |=> flag_r[1]) // [RULE1]
    else $error("edge 1 did not set flag");
  edgeSet0_a: assert property (edgeMode0_s |=> flag_r[0]) // [RULE2]
    else $error("edge 0 did not set flag");
  levelPin0_a: assert property (pinHeldLow0_s ##1 !sel_r[0] |-> flag_r[0]) // [RULE2]
    else $error("low level 0 did not set flag");
  vecClear_a: assert property (sel_r[1] && vecAck[1] && !fallPulse[1] && !swWr[1]
                               |=> !flag_r[1]) // [RULE3]
    else $error("vector entry did not clear edge flag");
  levelTrack_a: assert property (!sel_r[1] && !sel_nxt[1] ##1 !sel_r[1]
                                 |-> flag_r[1] == $past(lowLevel[1])) // [RULE4]
    else $error("level flag not following source");
  edgeHold_a: assert property (sel_r[0] && flag_r[0] && !vecAck[0] && !swWr[0]
                               |=> flag_r[0]) // [RULE5]
    else $error("edge flag dropped on its own");
  resetZero_a: assert property (disable iff (1'b0) $past(srst) |-> nibble == 4'h0) // [RULE6]
    else $error("control bits not zero after reset");
  timerBits_a: assert property (sfrRdData[7:4] == 4'h0) // [RULE7]
    else $error("timer bits driven by this block");
  readBack_a: assert property (sfrRdEn && sfrAddr == `EDC_CTRL_ADDR
                               |=> sfrRdData[3:0] == $past(nibble)) // [RULE8]
    else $error("control byte read mismatch");

endmodule

// ==== verification/edc_irq_source.sv ====
// Purpose: External devices pulling the two interrupt pins low
// Assumes: Pins carry pull-ups, so a released pin reads high
// Notes:   Bench commands each hold; no clock needed on this side
`timescale 1ns/1ps

module edc_irq_source (
  input  wire logic [1:0] holdLow,
  output logic            extIrq0PinN,
  output logic            ext_irq1_pinN
);
  // Release means pull-up level; source removes a level request itself
  assign extIrq0PinN   = ~holdLow[0];
  assign ext_irq1_pinN = ~holdLow[1];
endmodule

// ==== verification/test_external_interrupt_detect.sv ====
// Purpose: Self-checking bench for the external interrupt detect block
// Assumes: Inputs change at falling edges; design samples on rising edges
// Notes:   Waits of 6 cycles cover the 5-edge pin-to-request latency with margin
`timescale 1ns/1ps

module test_external_interrupt_detect;
  import edc_pkg::*;
  logic       core_clk, srst, sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, bitRdVal;
  logic       extIrq0PinN, ext_irq1_pinN;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, bitAddr, d;
  logic [1:0] vecAck, extReq, holdLow;
  int         fail_count, comparisons;

  edc_irq_source src (.holdLow(holdLow), .extIrq0PinN(extIrq0PinN),
    .ext_irq1_pinN(ext_irq1_pinN));
  edc_ext_irq uut (.core_clk(core_clk), .srst(srst), .extIrq0PinN(extIrq0PinN),
    .ext_irq1_pinN(ext_irq1_pinN), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .bitAddr(bitAddr), .bitWrEn(bitWrEn), .bitWrVal(bitWrVal),
    .bitRdVal(bitRdVal), .vecAck(vecAck), .extReq(extReq));

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Strobes last one cycle, so every task is entered at a falling edge
  task automatic byte_wr(input logic [7:0] a, input logic [7:0] v);
    sfrAddr   = a;
    sfrWrData = v;
    sfrWrEn   = 1'h1;
    wait_n(1);
    sfrWrEn   = 1'h0;
  endtask

  task automatic byte_rd(output logic [7:0] v);
    sfrAddr = 8'h88;
    sfrRdEn = 1'h1;
    wait_n(1);
    sfrRdEn = 1'h0;
    v       = sfrRdData;
  endtask

  task automatic bit_wr(input logic [7:0] a, input logic v);
    bitAddr  = a;
    bitWrVal = v;
    bitWrEn  = 1'h1;
    wait_n(1);
    bitWrEn  = 1'h0;
  endtask

  task automatic bit_rd(input logic [7:0] a, output logic [7:0] v);
    bitAddr = a;
    wait_n(1);
    v = {7'h00, bitRdVal};
  endtask

  task automatic ack(input logic [1:0] i);
    vecAck = i;
    wait_n(1);
    vecAck = 2'h0;
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    {sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, vecAck, holdLow} = '0;
    {sfrAddr, sfrWrData, bitAddr} = '0;
    srst = 1'h1;
    wait_n(3);
    srst = 1'h0;
    byte_rd(d);
    chk(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bit_rd(8'h88 + 8'(i), d);
      chk(d, 8'h00);
    end
    // Level mode: ack and writes must not drop a held request
    holdLow = 2'h1;
    wait_n(6);
    chk({6'h00, extReq}, 8'h01);
    ack(2'h1);
    bit_wr(8'h89, 1'h0);
    wait_n(1);
    chk({6'h00, extReq}, 8'h01);
    holdLow = 2'h0;
    wait_n(6);
    chk({6'h00, extReq}, 8'h00);
    // Edge mode both; timer nibble and foreign address ignored
    byte_wr(8'h88, 8'hF5);
    byte_rd(d);
    chk(d, 8'h05);
    byte_wr(8'h8C, 8'h0A);
    byte_rd(d);
    chk(d, 8'h05);
    holdLow = 2'h2;
    wait_n(6);
    chk({6'h00, extReq}, 8'h02);
    ack(2'h2);
    wait_n(3);
    chk({6'h00, extReq}, 8'h00);
    // Pin 1 stays low with no new fall; only pin 0 sets
    holdLow = 2'h3;
    wait_n(6);
    chk({6'h00, extReq}, 8'h01);
    bit_rd(8'h89, d);
    chk(d, 8'h01);
    bit_wr(8'h89, 1'h0);
    wait_n(1);
    chk({6'h00, extReq}, 8'h00);
    // Back to level mode on pin 1 while it is still low
    bit_wr(8'h8A, 1'h0);
    wait_n(6);
    chk({6'h00, extReq}, 8'h02);
    // Reset in mid-run clears flags and selects
    srst = 1'h1;
    wait_n(1);
    srst    = 1'h0;
    holdLow = 2'h0;
    byte_rd(d);
    chk(d, 8'h00);
    end_of_test();
  end

  // Whole run needs well under 200 cycles
  initial begin
    #(2000 * 50);
    fail_count++;
    end_of_test();
  end
endmodule
